// [logic/smb_pkg.sv]
// package: register map, field positions, reset values and crc constants
package smb_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BAUD = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [3:0] ADDR_CRC  = 4'h3;
    // field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int STAT_CRCRDY_BIT = 0;
    localparam int STAT_BUSY_BIT   = 1;
    localparam int STAT_STALL_BIT  = 2;
    localparam int RATE_W          = 3;
    // reset values
    localparam logic       CTRL_EN_RESET = 1'b0;
    localparam logic [2:0] RATE_RESET    = 3'h0;
    localparam logic [7:0] CRC_INIT      = 8'h00;
    // crc polynomial x^8+x^2+x+1 without the x^8 term
    localparam logic [7:0] CRC_POLY      = 8'h07;
    // timing counts: bits per byte and smallest baud divisor
    localparam int          CRC_BITS      = 8;
    localparam logic [11:0] BAUD_BASE_DIV = 12'h014;
    localparam int          DIV_W         = 12;
endpackage

// [logic/smb_byte_if.sv]
// interface: byte stream with valid and ready between buffer and crc engine
`timescale 1ns/1ps
interface smb_byte_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [logic/smb_fifo2.sv]
// two-entry byte buffer between the shifter and the crc engine
`timescale 1ns/1ps
module smb_fifo2 (
    // clock and control
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       flush,
    // filling side
    input  wire logic       inValid,
    input  wire logic [7:0] inData,
    output logic            inReady,
    // draining side
    smb_byte_if.src         out
);
    logic [7:0] mem [2];
    logic       wrIdx;
    logic       rdIdx;
    logic [1:0] count;
    logic       push;
    logic       pop;

    // honest full and empty
    assign inReady   = (count != 2'h2);
    assign out.valid = (count != 2'h0);
    assign out.data  = mem[rdIdx];
    assign push      = inValid && inReady;
    assign pop       = out.valid && out.ready;

    // storage, addressed by the write index
    always_ff @(posedge clk_sys) begin
        if (clk_en && push) begin
            mem[wrIdx] <= inData;
        end
    end

    // pointers and occupancy; flush drops held bytes on disable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrIdx <= 1'b0;
            rdIdx <= 1'b0;
            count <= 2'h0;
        end else if (clk_en) begin
            if (flush) begin
                wrIdx <= 1'b0;
                rdIdx <= 1'b0;
                count <= 2'h0;
            end else begin
                if (push) wrIdx <= ~wrIdx;
                if (pop) rdIdx <= ~rdIdx;
                count <= count + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    // a byte taken while nothing drains must stay counted, or a stall loses it
    a_fifo_keep_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && !flush && push && !pop) |=> (count == $past(count) + 2'h1))
        else $error("buffer dropped a taken byte");
endmodule

// [logic/smb_crc8.sv]
// serial packet error code engine, one bit per enabled clock
`timescale 1ns/1ps
module smb_crc8 (
    // clock and control
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       accClr,
    // byte stream in
    smb_byte_if.snk         in,
    // result
    output logic [7:0]      crc,
    output logic            byteStart,
    output logic            byteDone
);
    typedef enum logic {CRC_IDLE, CRC_SHIFT} smb_crc_state_t;
    smb_crc_state_t state;
    logic [7:0]     shReg;
    logic [2:0]     bitCnt;
    logic           fb;

    // the engine takes a byte only when idle, so the buffer fills behind it
    assign in.ready  = (state == CRC_IDLE);
    assign byteStart = in.valid && in.ready;
    assign fb        = crc[7] ^ shReg[7];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state    <= CRC_IDLE;
            crc      <= smb_pkg::CRC_INIT;
            shReg    <= 8'h00;
            bitCnt   <= 3'h0;
            byteDone <= 1'b0;
        end else if (clk_en) begin
            byteDone <= 1'b0;
            unique case (state)
                CRC_IDLE: begin
                    if (accClr) crc <= smb_pkg::CRC_INIT;
                    if (byteStart) begin
                        shReg  <= in.data;
                        bitCnt <= 3'h0;
                        state  <= CRC_SHIFT;
                    end
                end
                CRC_SHIFT: begin
                    crc    <= {crc[6:0], 1'b0} ^ (fb ? smb_pkg::CRC_POLY : 8'h00);
                    shReg  <= {shReg[6:0], 1'b0};
                    bitCnt <= bitCnt + 3'h1;
                    if (bitCnt == 3'(smb_pkg::CRC_BITS - 1)) begin
                        byteDone <= 1'b1;
                        state    <= CRC_IDLE;
                    end
                end
            endcase
        end
    end

    sequence s_accept;
        in.valid && in.ready;
    endsequence

    a_crc_latency: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        s_accept |-> ##9 byteDone)
        else $error("crc byte not ready nine cycles after acceptance");
    a_acc_init: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (accClr && state == CRC_IDLE) |=> (crc == 8'h00))
        else $error("accumulator not cleared at start");
endmodule

// [logic/smb_pec_top.sv]
// packet error code, baud divider and arbitration recovery for the two-wire controller
// Summary of operation
// - while enabled with the ready flag set, the crc register shows the crc of the last byte.
// - each received or sent byte yields a crc byte that is loaded and then flags ready.
// - a processor read of the crc register clears the ready flag.
// - hardware clears the ready flag before the next crc byte is loaded; the flag stays set when the next byte starts in the cycle a crc byte loads.
// - rate codes 0 to 7 divide the bus clock by 20, 40, 80, 160, 320, 640, 1280 and 2560.
// - on lost arbitration as master both data and clock lines are released at once.
// - after lost arbitration busy stays set and the block stalls until a stop is seen.
// - clearing enable releases the bus and clears busy; setting it resumes operation.
// - send byte is start, address write, ack, command, ack, optional acked pec, stop.
// - receive byte is start, address read, ack, data, nak; with pec data acked, pec naked.
// - write byte or word sends command then one or two acked bytes, optional acked pec.
// - read byte or word writes command, repeated start read, last byte or pec naked.
// - process call writes command and a word, then reads a word low byte first.
// - block transfers carry command, count n and n bytes; reads end with a nak.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module smb_pec_top (
    // clock, reset, enable
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [7:0]      regRdata,
    // bus pins, open drain
    input  wire logic       sdaIn,
    input  wire logic       sclIn,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            sclOut,
    output logic            sclOe,
    // shifter side
    input  wire logic       byteValid,
    input  wire logic [7:0] byteData,
    output logic            byteReady,
    input  wire logic       shSdaDrive,
    input  wire logic       shSclDrive,
    input  wire logic       isMaster,
    input  wire logic       arbLost,
    // status to the shifter
    output logic            baudTick,
    output logic            moduleEnable,
    output logic            busBusy,
    output logic            stalled
);
    logic [2:0]  rateCode;
    logic [7:0]  pecCrc;
    logic        crcReady;
    logic [7:0]  crcOut;
    logic        crcStart;
    logic        crcDone;
    logic [2:0]  sdaSync;
    logic [2:0]  sclSync;
    logic        sdaLvl;
    logic        sclLvl;
    logic        sdaPrev;
    logic        startSeen;
    logic        stopSeen;
    logic        rdCrc;
    logic [11:0] baudCnt;
    logic [11:0] baudDiv;
    logic [7:0]  next_rdata;

    smb_byte_if  crcIf ();

    // divisor is the base figure doubled once per rate code step
    function automatic logic [11:0] div_of(input logic [2:0] code);
        div_of = smb_pkg::BAUD_BASE_DIV << code;
    endfunction

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------

    // three stages; stage 0 feeds stage 1 only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sdaSync <= 3'h7;
            sclSync <= 3'h7;
        end else if (clk_en) begin
            sdaSync <= {sdaSync[1:0], sdaIn};
            sclSync <= {sclSync[1:0], sclIn};
        end
    end

    // a level change counts once stages 1 and 2 agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sdaLvl  <= 1'b1;
            sclLvl  <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (clk_en) begin
            if (sdaSync[1] == sdaSync[2]) sdaLvl <= sdaSync[2];
            if (sclSync[1] == sclSync[2]) sclLvl <= sclSync[2];
            sdaPrev <= sdaLvl;
        end
    end

    // frame edges
    // start: data falls while clock high; stop: data rises while clock high
    assign startSeen = sclLvl && sdaPrev && !sdaLvl;
    assign stopSeen  = sclLvl && !sdaPrev && sdaLvl;

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------

    // control register: enable bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            moduleEnable <= smb_pkg::CTRL_EN_RESET;
        end else if (clk_en && regWr && regAddr == smb_pkg::ADDR_CTRL) begin
            moduleEnable <= regWdata[smb_pkg::CTRL_EN_BIT];
        end
    end

    // baud divider select: only the rate field is stored
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rateCode <= smb_pkg::RATE_RESET;
        end else if (clk_en && regWr && regAddr == smb_pkg::ADDR_BAUD) begin
            rateCode <= regWdata[smb_pkg::RATE_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // baud divider
    // --------------------------------------------------------------

    assign baudDiv = div_of(rateCode);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            baudCnt  <= 12'h000;
            baudTick <= 1'b0;
        end else if (clk_en) begin
            if (!moduleEnable || baudCnt >= baudDiv - 12'h001) begin
                baudCnt  <= 12'h000;
                baudTick <= moduleEnable;
            end else begin
                baudCnt  <= baudCnt + 12'h001;
                baudTick <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // bus busy and arbitration stall
    // --------------------------------------------------------------

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busBusy <= 1'b0;
        end else if (clk_en) begin
            if (!moduleEnable) busBusy <= 1'b0;
            else if (startSeen) busBusy <= 1'b1;
            else if (stopSeen) busBusy <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stalled <= 1'b0;
        end else if (clk_en) begin
            if (!moduleEnable) stalled <= 1'b0;
            else if (arbLost && isMaster) stalled <= 1'b1;
            else if (stopSeen) stalled <= 1'b0;
        end
    end

    // release lines at once
    // gated combinationally so the release does not wait for a clock edge
    assign sdaOe  = shSdaDrive && moduleEnable && !stalled && !arbLost;
    assign sclOe  = shSclDrive && moduleEnable && !stalled && !arbLost;
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;

    // --------------------------------------------------------------
    // byte path: buffer then crc engine
    // --------------------------------------------------------------

    // every framed byte
    // stalled or disabled blocks take no bytes; disable also flushes
    smb_fifo2 u_fifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .flush   (!moduleEnable),
        .inValid (byteValid && moduleEnable && !stalled),
        .inData  (byteData),
        .inReady (byteReady),
        .out     (crcIf)
    );

    // accumulator restarts at a fresh start; a repeated start continues it
    smb_crc8 u_crc (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .accClr    (startSeen && !busBusy),
        .in        (crcIf),
        .crc       (crcOut),
        .byteStart (crcStart),
        .byteDone  (crcDone)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pecCrc <= smb_pkg::CRC_INIT;
        end else if (clk_en && crcDone) begin
            pecCrc <= crcOut;
        end
    end

    assign rdCrc = regRd && regAddr == smb_pkg::ADDR_CRC;

    // ready flag: a load in the same cycle as a read wins over the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            crcReady <= 1'b0;
        end else if (clk_en) begin
            if (!moduleEnable) crcReady <= 1'b0;
            else if (crcDone) crcReady <= 1'b1;
            else if (rdCrc) crcReady <= 1'b0;
            else if (crcStart) crcReady <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // register reads, data valid one cycle after the strobe
    // --------------------------------------------------------------

    always_comb begin
        next_rdata = 8'h00;
        unique case (regAddr)
            smb_pkg::ADDR_CTRL: next_rdata[smb_pkg::CTRL_EN_BIT] = moduleEnable;
            smb_pkg::ADDR_BAUD: next_rdata[smb_pkg::RATE_W-1:0] = rateCode;
            smb_pkg::ADDR_STAT: begin
                next_rdata[smb_pkg::STAT_CRCRDY_BIT] = crcReady;
                next_rdata[smb_pkg::STAT_BUSY_BIT]   = busBusy;
                next_rdata[smb_pkg::STAT_STALL_BIT]  = stalled;
            end
            smb_pkg::ADDR_CRC:  next_rdata = moduleEnable ? pecCrc : 8'h00;
            default:            next_rdata = 8'h00;
        endcase
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (clk_en) begin
            regRdata <= regRd ? next_rdata : 8'h00;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------

    // helper: cycles since the divider last wrapped; a tick ends each span
    logic [11:0] sinceTick;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !clk_en || baudCnt == 12'h000) sinceTick <= 12'h000;
        else sinceTick <= sinceTick + 12'h001;
    end

    sequence s_load;
        crcDone && moduleEnable;
    endsequence

    sequence s_shown;
        crcReady && pecCrc == $past(crcOut);
    endsequence

    a_crc_load_flag: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        s_load |=> s_shown)
        else $error("crc not loaded with ready flag");
    a_crc_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (rdCrc && !crcDone) |=> !crcReady)
        else $error("crc read did not clear ready flag");
    a_crc_fresh_flag: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (crcStart && !crcDone) |=> !crcReady ##9 crcReady)
        else $error("ready flag not refreshed per byte");
    a_crc_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (rdCrc && moduleEnable && crcReady) |=> regRdata == $past(pecCrc))
        else $error("crc read returns wrong value");
    a_baud_period: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        sinceTick < div_of(rateCode))
        else $error("baud tick spacing exceeds divisor");
    a_arb_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (arbLost || stalled) |-> !sdaOe && !sclOe)
        else $error("line driven after arbitration loss");
    a_stall_busy: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (stalled && !stopSeen && moduleEnable) |=> stalled)
        else $error("stall dropped without stop");
    a_stop_ends_stall: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (stopSeen && !arbLost) |=> !stalled)
        else $error("stall held past stop");
    a_disable_clear: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        !moduleEnable |=> !busBusy && !stalled && !crcReady)
        else $error("disable did not clear busy state");

    // bus state: busy follows a start, and only a loss as master stalls
    sequence s_lost;
        arbLost && isMaster && moduleEnable;
    endsequence

    sequence s_held;
        busBusy && stalled && !stopSeen && moduleEnable;
    endsequence

    a_stall_on_loss: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        s_lost |=> stalled)
        else $error("no stall after arbitration loss");
    a_busy_in_stall: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        s_held |=> busBusy)
        else $error("busy dropped while stalled");
    a_start_sets_busy: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        (startSeen && moduleEnable) |=> busBusy)
        else $error("start not shown as busy");
    a_tick_off: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        !moduleEnable |=> !baudTick)
        else $error("baud tick while disabled");
    // read data stands one cycle only, so a late sampler sees zero, not stale data
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n || !clk_en)
        !regRd |=> (regRdata == 8'h00))
        else $error("read data outside its cycle");
endmodule

// [verification/smb_bus_partner.sv]
// far-side bus party: pull-ups, wired-and lines and a second master framing the bus
`timescale 1ns/1ps
module smb_bus_partner (
    // clock
    input  wire logic clk_sys,
    // design pin enables
    input  wire logic sdaOe,
    input  wire logic sclOe,
    // resolved line levels
    output logic      sdaLine,
    output logic      sclLine
);
    logic pullSda;
    logic pullScl;
    // open drain with pull-up: any party pulling low wins
    assign sdaLine = !(pullSda || sdaOe);
    assign sclLine = !(pullScl || sclOe);
    // idle bus, both lines released
    initial begin
        pullSda = 1'b0;
        pullScl = 1'b0;
    end
    task automatic frame_start();
        @(posedge clk_sys);
        pullSda <= 1'b1;
        repeat (8) @(posedge clk_sys);
        pullScl <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic frame_stop();
        @(posedge clk_sys);
        pullSda <= 1'b1;
        pullScl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        pullSda <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// [verification/smbus_pec_crc_and_baud_divider_tb.sv]
// self-checking bench for the packet error code, baud divider and recovery block
`timescale 1ns/1ps
module smbus_pec_crc_and_baud_divider_tb;
    logic       clk_sys;
    logic       rst_n;
    logic       clk_en;
    logic [3:0] regAddr;
    logic [7:0] regWdata;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdata;
    logic       sdaLine;
    logic       sclLine;
    logic       sdaOe;
    logic       sclOe;
    logic       byteValid;
    logic [7:0] byteData;
    logic       byteReady;
    logic       shSdaDrive;
    logic       shSclDrive;
    logic       isMaster;
    logic       arbLost;
    logic       baudTick;
    logic       moduleEnable;
    logic       busBusy;
    logic       stalled;
    logic       sawFull;
    int         badCount;
    int         testsRun;

    // design under test, pins resolved by the partner
    smb_pec_top smb_pec_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .sdaIn(sdaLine), .sclIn(sclLine), .sdaOut(), .sdaOe(sdaOe),
        .sclOut(), .sclOe(sclOe), .byteValid(byteValid), .byteData(byteData),
        .byteReady(byteReady), .shSdaDrive(shSdaDrive), .shSclDrive(shSclDrive),
        .isMaster(isMaster), .arbLost(arbLost), .baudTick(baudTick),
        .moduleEnable(moduleEnable), .busBusy(busBusy), .stalled(stalled));
    smb_bus_partner smb_bus_partner_inst (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclOe(sclOe),
        .sdaLine(sdaLine), .sclLine(sclLine));

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    // compare tasks, one per kind of result
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chkn(input int got, input int exp);
        chk8(got[7:0], exp[7:0]);
        chk8(got[15:8], exp[15:8]);
    endtask

    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // register port: one-cycle strobes, read data only in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        d = regRdata;
    endtask

    // bench-side pec reference, bitwise
    function automatic logic [7:0] pec(input logic [7:0] acc, input logic [7:0] b);
        logic [7:0] c;
        c = acc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ smb_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // offer one byte and hold it until the buffer has room
    task automatic send_byte(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        byteValid <= 1'b1;
        byteData  <= d;
        @(negedge clk_sys);
        while (byteReady !== 1'b1 && n < 100) begin
            sawFull = 1'b1;
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        byteValid <= 1'b0;
    endtask

    // poll status until the crc flag shows, bounded
    task automatic wait_flag();
        logic [7:0] s;
        s = 8'h00;
        for (int n = 0; n < 30 && s[0] !== 1'b1; n++) begin
            reg_rd(smb_pkg::ADDR_STAT, s);
        end
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (baudTick !== 1'b1 && n < 3000);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        reg_rd(smb_pkg::ADDR_CTRL, d);
        chk8(d, 8'h00);
        reg_rd(smb_pkg::ADDR_STAT, d);
        chk8(d, 8'h00);
        reg_wr(4'h9, 8'hff);
        reg_rd(4'h9, d);
        chk8(d, 8'h00);
    endtask

    task automatic t_baud();
        logic [7:0] d;
        int n;
        for (int code = 0; code < 8; code++) begin
            reg_wr(smb_pkg::ADDR_BAUD, code[7:0]);
            reg_rd(smb_pkg::ADDR_BAUD, d);
            chk8(d, code[7:0]);
            wait_tick(n);
            wait_tick(n);
            chkn(n, 20 << code);
        end
    endtask

    task automatic t_crc();
        logic [7:0] d;
        logic [7:0] acc;
        smb_bus_partner_inst.frame_start();
        send_byte(8'ha5);
        wait_flag();
        acc = pec(8'h00, 8'ha5);
        reg_rd(smb_pkg::ADDR_CRC, d);
        chk8(d, acc);
        reg_rd(smb_pkg::ADDR_STAT, d);
        chk1(d[0], 1'b0);
        send_byte(8'h3c);
        wait_flag();
        send_byte(8'hff);
        reg_rd(smb_pkg::ADDR_STAT, d);
        chk1(d[0], 1'b0);
        wait_flag();
        acc = pec(pec(acc, 8'h3c), 8'hff);
        reg_rd(smb_pkg::ADDR_CRC, d);
        chk8(d, acc);
        // burst fills the two-entry buffer; no word may be lost
        for (int i = 0; i < 5; i++) begin
            send_byte(8'h10 + i[7:0]);
            acc = pec(acc, 8'h10 + i[7:0]);
        end
        chk1(sawFull, 1'b1);
        repeat (60) @(posedge clk_sys);
        reg_rd(smb_pkg::ADDR_CRC, d);
        chk8(d, acc);
        smb_bus_partner_inst.frame_stop();
        smb_bus_partner_inst.frame_start();
        send_byte(8'h01);
        wait_flag();
        reg_rd(smb_pkg::ADDR_CRC, d);
        chk8(d, pec(8'h00, 8'h01));
    endtask

    task automatic t_arb();
        logic [7:0] d;
        @(posedge clk_sys);
        isMaster   <= 1'b1;
        shSdaDrive <= 1'b1;
        shSclDrive <= 1'b1;
        @(posedge clk_sys);
        chk1(sdaOe, 1'b1);
        chk1(sclOe, 1'b1);
        arbLost <= 1'b1;
        #1;
        chk1(sdaOe, 1'b0);
        chk1(sclOe, 1'b0);
        repeat (3) @(posedge clk_sys);
        arbLost    <= 1'b0;
        isMaster   <= 1'b0;
        shSdaDrive <= 1'b0;
        shSclDrive <= 1'b0;
        reg_rd(smb_pkg::ADDR_CRC, d);
        send_byte(8'h77);
        repeat (40) @(posedge clk_sys);
        reg_rd(smb_pkg::ADDR_STAT, d);
        chk8(d, 8'h06);
        smb_bus_partner_inst.frame_stop();
        chk1(busBusy, 1'b0);
        chk1(stalled, 1'b0);
    endtask

    task automatic t_disable();
        logic [7:0] d;
        smb_bus_partner_inst.frame_start();
        chk1(busBusy, 1'b1);
        @(posedge clk_sys);
        shSdaDrive <= 1'b1;
        reg_wr(smb_pkg::ADDR_CTRL, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk1(busBusy, 1'b0);
        chk1(sdaOe, 1'b0);
        reg_rd(smb_pkg::ADDR_CRC, d);
        chk8(d, 8'h00);
        @(posedge clk_sys);
        shSdaDrive <= 1'b0;
        reg_wr(smb_pkg::ADDR_CTRL, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk1(moduleEnable, 1'b1);
        smb_bus_partner_inst.frame_stop();
    endtask

    // main sequence: reset for 3 cycles, then the scenarios
    initial begin
        clk_sys    = 1'b0;
        rst_n      = 1'b0;
        clk_en     = 1'b1;
        regAddr    = 4'h0;
        regWdata   = 8'h00;
        regWr      = 1'b0;
        regRd      = 1'b0;
        byteValid  = 1'b0;
        byteData   = 8'h00;
        shSdaDrive = 1'b0;
        shSclDrive = 1'b0;
        isMaster   = 1'b0;
        arbLost    = 1'b0;
        sawFull    = 1'b0;
        badCount   = 0;
        testsRun   = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        reg_wr(smb_pkg::ADDR_CTRL, 8'h01);
        t_baud();
        t_crc();
        t_arb();
        t_disable();
        wrapUp();
    end

    // watchdog: the scenarios need about 11000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        badCount++;
        wrapUp();
    end
endmodule
